// ===== rtl/aux_adc_map.svh
`ifndef AUX_ADC_MAP_SVH
`define AUX_ADC_MAP_SVH

// Serial instruction word layout
`define AUX_WORD_W       16
`define AUX_ADDR_MSB     15
`define AUX_ADDR_LSB     12
`define AUX_MODE_ADDR    4'h9
`define AUX_ADDR_NONE    4'hf

// Converter mode register, width and reset value
`define AUX_MODE_W       11
`define AUX_MODE_RESET   11'h000

// Field positions inside the mode register
`define AUX_F_START      0
`define AUX_F_REF        1
`define AUX_F_INSEL      2
`define AUX_F_AVG        4
`define AUX_F_DIV        7
`define AUX_F_OE         10

// Conversion figures
`define AUX_RES_W        10
`define AUX_AVG_LOG_MAX  3'h5
`define AUX_CONV_EDGES   12

`endif

// ===== rtl/aux_adc_pkg.sv
package aux_adc_pkg;
`include "aux_adc_map.svh"

   // Mode register, msb first
   typedef struct packed {
      logic       out_en;    // Result shift-out enable
      logic [2:0] div;       // Conversion clock divisor code
      logic [2:0] avg;       // Averaging count code
      logic [1:0] in_sel;    // Input multiplexer code
      logic       ref_sel;   // Reference choice
      logic       start;     // Start-convert, self clearing
   } mode_t;

   // Conversion sequencer states
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_SAMPLE,
      SEQ_BITS,
      SEQ_LOAD
   } seq_t;

   // Serial input shifter state
   typedef struct packed {
      logic [`AUX_WORD_W-1:0] sh;
   } shin_state_t;

   // Core state on the system clock
   typedef struct packed {
      logic                                 cs_s1;
      logic                                 cs_s2;
      logic                                 cs_s3;
      logic                                 sck_s1;
      logic                                 sck_s2;
      logic                                 sck_s3;
      mode_t                                mode;
      mode_t                                cfg;
      seq_t                                 seq;
      logic [3:0]                           bit_idx;
      logic [3:0]                           edge_cnt;
      logic [4:0]                           avg_left;
      logic [`AUX_RES_W+4:0]                acc;
      logic [`AUX_RES_W-1:0]                sar;
      logic [`AUX_RES_W-1:0]                result;
      logic [`AUX_RES_W-1:0]                out_sh;
      logic                                 ready;
      logic                                 reading;
      logic                                 dout;
      logic                                 dout_oe;
      logic                                 sample;
      logic [15:0]                          cyc;
   } seq_state_t;

endpackage : aux_adc_pkg

// ===== rtl/aux_spi_if.sv
`timescale 1ns/1ps
`include "aux_adc_map.svh"

// Received instruction word, link side to core side
interface aux_spi_if;
   logic [`AUX_WORD_W-1:0] word;   // Last bits shifted in

   modport link (output word);
   modport core (input word);
endinterface : aux_spi_if

// ===== rtl/aux_spi_shift_in.sv
`timescale 1ns/1ps
`include "aux_adc_map.svh"

// Serial input shifter, runs on the link clock
module aux_spi_shift_in
   import aux_adc_pkg::*;
(
   input  wire logic   sclk,   // Serial clock
   input  wire logic   cs_n,   // Chip select, active low
   input  wire logic   din,    // Serial data in
   aux_spi_if.link     spi     // Word towards the core
);

   shin_state_t st_r;    // Shifter state
   shin_state_t st_nxt;  // Next shifter state

   // Shift msb first while selected
   always_comb begin
      st_nxt = st_r;
      if (!cs_n) begin
         st_nxt.sh = {st_r.sh[`AUX_WORD_W-2:0], din};
      end
   end

   // Data only; the word is qualified by the core's chip select edge
   always_ff @(posedge sclk) begin
      st_r <= st_nxt;
   end

   assign spi.word = st_r.sh;

endmodule : aux_spi_shift_in

// ===== rtl/aux_conv_clk_div.sv
`timescale 1ns/1ps

// Power-of-two divider giving one tick per conversion clock edge
module aux_conv_clk_div #(
   parameter int CODE_W = 3   // Divisor code width
) (
   input  wire logic              clk,       // System clock
   input  wire logic              resetn,    // Synchronous reset, active low
   input  wire logic              restart,   // Realign the divider
   input  wire logic [CODE_W-1:0] div_code,  // Divide by two to this power
   output logic                   tick       // One-cycle conversion edge
);

   localparam int CNT_W = (1 << CODE_W) - 1;   // Counter holds divisor minus one

   // Refuse codes that the counter cannot serve
   generate
      if (CODE_W < 1 || CODE_W > 4) begin : g_bad_code
         $error("aux_conv_clk_div: CODE_W out of range");
      end
   endgenerate

   typedef struct packed {
      logic [CNT_W-1:0] cnt;    // Cycles since last tick
      logic             tick;   // Registered tick
   } div_state_t;

   div_state_t       st_r;    // Divider state
   div_state_t       st_nxt;  // Next divider state
   logic [CNT_W-1:0] lim;     // Terminal count

   assign lim = CNT_W'((32'h1 << div_code) - 32'h1);

   // Count up to the terminal count, then tick
   always_comb begin
      st_nxt      = st_r;
      st_nxt.tick = 1'b0;
      st_nxt.cnt  = st_r.cnt + CNT_W'(1);
      if (st_r.cnt == lim) begin
         st_nxt.cnt  = '0;
         st_nxt.tick = 1'b1;
      end
      if (restart) begin
         st_nxt.cnt  = '0;
         st_nxt.tick = 1'b0;
      end
   end

   // Register the state
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick = st_r.tick;

   // Divide by four: ticks exactly four cycles apart
   property p_div_pace;
      @(posedge clk) disable iff (!resetn)
      (st_r.tick && !restart && div_code == 3'h2) ##1 (!restart && div_code == 3'h2) [*4]
      |-> st_r.tick && !$past(st_r.tick);
   endproperty
   a_div_pace: assert property (p_div_pace)
      else $error("divider pace wrong for divide by four");

endmodule : aux_conv_clk_div

// ===== rtl/aux_adc_sequencer.sv
`timescale 1ns/1ps
`include "aux_adc_map.svh"

// Function
// - Start bit written while idle starts conversion.
// - Start bit clears after whole sequence ends.
// - Start writes during conversion are ignored.
// - Reference bit: zero internal, one analog supply.
// - Input code drives the four-way multiplexer.
// - Averaging code gives 1 to 32 conversions.
// - One conversion takes twelve conversion-clock edges.
// - Every averaged conversion also takes twelve edges.
// - Conversion clock is clock over power of two.
// - Serial output driven high while busy.
// - At completion store result, drive output low.
// - Enabled result shifts out msb first, falling edges.
// - Output released when chip select returns high at the end of a read frame.
// - Disabled result output shifts nothing out.
// - Instructions accepted at any time on input.
// - Address all-ones changes no register.
// - Input msb first, latched at select rise.
module aux_adc_sequencer
   import aux_adc_pkg::*;
(
   input  wire logic                  clk,          // System clock
   input  wire logic                  resetn,       // Synchronous reset, active low
   input  wire logic                  sclk,         // Serial clock from the host
   input  wire logic                  cs_n,         // Chip select, active low
   input  wire logic                  din,          // Serial data in
   input  wire logic                  adc_cmp,      // Comparator: input above trial
   output logic                       dout,         // Serial data out value
   output logic                       dout_oe,      // Serial data out enable
   output logic                       conv_busy,    // Start bit as stored
   output logic                       adc_sample,   // Sample strobe to the analog
   output logic [`AUX_RES_W-1:0]      adc_trial,    // Approximation trial code
   output logic                       adc_ref_sel,  // Reference choice
   output logic [1:0]                 adc_in_sel    // Multiplexer choice
);

   aux_spi_if  spi ();     // Received word

   seq_state_t st_r;       // Core state
   seq_state_t st_nxt;     // Next core state

   logic                   tick;      // Conversion clock edge
   logic                   busy;      // Sequence running
   logic                   cs_rise;   // Select deasserted
   logic                   cs_fall;   // Select asserted
   logic                   sck_fall;  // Serial clock fell
   logic                   wr_mode;   // Word addressed to mode register
   logic                   start_go;  // Conversion accepted
   logic                   done;      // Last edge of sequence
   logic [2:0]             avg_log;   // Running averaging exponent
   logic [`AUX_RES_W+4:0]  acc_sum;   // Accumulator plus current result
   logic [`AUX_RES_W+4:0]  acc_avg;   // Mean before truncation

   // Averaging code to exponent, codes above five give 32
   function automatic logic [2:0] avg_log_f(input logic [2:0] code);
      return (code > `AUX_AVG_LOG_MAX) ? `AUX_AVG_LOG_MAX : code;
   endfunction : avg_log_f

   // Link side shifter
   aux_spi_shift_in u_shift_in (
      .sclk (sclk),
      .cs_n (cs_n),
      .din  (din),
      .spi  (spi.link)
   );

   // Conversion clock divider
   aux_conv_clk_div #(
      .CODE_W (3)
   ) u_div (
      .clk      (clk),
      .resetn   (resetn),
      .restart  (start_go),
      .div_code (st_r.cfg.div),
      .tick     (tick)
   );

   // Decodes from synchronised pins
   assign busy     = st_r.seq != SEQ_IDLE;
   assign cs_rise  = st_r.cs_s2 & ~st_r.cs_s3;
   assign cs_fall  = ~st_r.cs_s2 & st_r.cs_s3;
   assign sck_fall = ~st_r.sck_s2 & st_r.sck_s3;

   // Word is stable once select is high and the link clock idles
   assign wr_mode  = cs_rise &&
                     (spi.word[`AUX_ADDR_MSB:`AUX_ADDR_LSB] == `AUX_MODE_ADDR);
   assign start_go = wr_mode && !busy && spi.word[`AUX_F_START];
   assign done     = (st_r.seq == SEQ_LOAD) && tick && (st_r.avg_left == 5'h0);
   assign avg_log  = avg_log_f(st_r.cfg.avg);
   assign acc_sum  = st_r.acc + {5'h0, st_r.sar};
   assign acc_avg  = acc_sum >> avg_log;

   // Next state
   always_comb begin
      st_nxt        = st_r;
      st_nxt.sample = 1'b0;

      // Two-stage synchronisers plus edge stage
      st_nxt.cs_s1  = cs_n;
      st_nxt.cs_s2  = st_r.cs_s1;
      st_nxt.cs_s3  = st_r.cs_s2;
      st_nxt.sck_s1 = sclk;
      st_nxt.sck_s2 = st_r.sck_s1;
      st_nxt.sck_s3 = st_r.sck_s2;

      // Mode register write at select rise
      if (wr_mode) begin
         st_nxt.mode = mode_t'(spi.word[`AUX_MODE_W-1:0]);
         if (busy) begin
            st_nxt.mode.start = 1'b1;
         end
      end

      // Analog selections follow the register only while idle
      if (!busy) begin
         st_nxt.cfg = st_nxt.mode;
      end

      // Result read frame starts on select fall
      if (cs_fall && st_r.mode.out_en && st_r.ready && !busy) begin
         st_nxt.reading = 1'b1;
         st_nxt.out_sh  = st_r.result;
         st_nxt.dout    = st_r.result[`AUX_RES_W-1];
         st_nxt.dout_oe = 1'b1;
      end else if (sck_fall && st_r.reading && !st_r.cs_s2) begin
         // Next bit on each falling serial clock
         st_nxt.out_sh = {st_r.out_sh[`AUX_RES_W-2:0], 1'b0};
         st_nxt.dout   = st_r.out_sh[`AUX_RES_W-2];
      end

      // End of a read frame releases the pin
      if (cs_rise && st_r.reading) begin
         st_nxt.reading = 1'b0;
         st_nxt.dout_oe = 1'b0;
         st_nxt.ready   = 1'b0;
      end

      // Cycle count of the running sequence
      if (busy) begin
         st_nxt.cyc = st_r.cyc + 16'h1;
      end

      // Conversion sequencer
      case (st_r.seq)
         SEQ_IDLE: begin
            if (start_go) begin
               st_nxt.seq      = SEQ_SAMPLE;
               st_nxt.acc      = '0;
               st_nxt.avg_left = 5'((6'h1 << avg_log_f(st_nxt.mode.avg)) - 6'h1);
               st_nxt.dout     = 1'b1;
               st_nxt.dout_oe  = 1'b1;
               st_nxt.ready    = 1'b0;
               st_nxt.reading  = 1'b0;
               st_nxt.cyc      = 16'h0;
            end
         end
         SEQ_SAMPLE: begin
            // First edge samples the input
            if (tick) begin
               st_nxt.sample   = 1'b1;
               st_nxt.sar      = {1'b1, {(`AUX_RES_W-1){1'b0}}};
               st_nxt.bit_idx  = 4'(`AUX_RES_W-1);
               st_nxt.edge_cnt = 4'h1;
               st_nxt.seq      = SEQ_BITS;
            end
         end
         SEQ_BITS: begin
            // One edge per result bit, msb first
            if (tick) begin
               st_nxt.edge_cnt = st_r.edge_cnt + 4'h1;
               if (!adc_cmp) begin
                  st_nxt.sar[st_r.bit_idx] = 1'b0;
               end
               if (st_r.bit_idx != 4'h0) begin
                  st_nxt.sar[st_r.bit_idx-4'h1] = 1'b1;
                  st_nxt.bit_idx                = st_r.bit_idx - 4'h1;
               end else begin
                  st_nxt.seq = SEQ_LOAD;
               end
            end
         end
         SEQ_LOAD: begin
            // Last edge loads the result or starts the next average
            if (tick) begin
               st_nxt.acc = acc_sum;
               if (st_r.avg_left == 5'h0) begin
                  st_nxt.seq        = SEQ_IDLE;
                  st_nxt.result     = acc_avg[`AUX_RES_W-1:0];
                  st_nxt.ready      = 1'b1;
                  st_nxt.dout       = 1'b0;
                  st_nxt.mode.start = 1'b0;
               end else begin
                  st_nxt.avg_left = st_r.avg_left - 5'h1;
                  st_nxt.seq      = SEQ_SAMPLE;
               end
            end
         end
         default: begin
            st_nxt.seq = SEQ_IDLE;
         end
      endcase
   end

   // Register the state; select synchronisers rest high
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_r       <= '0;
         st_r.mode  <= mode_t'(`AUX_MODE_RESET);
         st_r.cfg   <= mode_t'(`AUX_MODE_RESET);
         st_r.cs_s1 <= 1'b1;
         st_r.cs_s2 <= 1'b1;
         st_r.cs_s3 <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from state flops
   assign dout        = st_r.dout;
   assign dout_oe     = st_r.dout_oe;
   assign conv_busy   = st_r.mode.start;
   assign adc_sample  = st_r.sample;
   assign adc_trial   = st_r.sar;
   assign adc_ref_sel = st_r.cfg.ref_sel;
   assign adc_in_sel  = st_r.cfg.in_sel;

   // Checks on the system clock
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence s_go;
      start_go;
   endsequence

   sequence s_busy_shown;
      busy && st_r.mode.start && st_r.dout && st_r.dout_oe;
   endsequence

   // Accepted start shows busy on the pin
   property p_start_busy;
      s_go |=> s_busy_shown;
   endproperty
   a_start_busy: assert property (p_start_busy)
      else $error("start not shown as busy");

   // Writes during a sequence do not stop it
   property p_ignore_busy;
      busy && wr_mode && !done |=> busy && st_r.mode.start;
   endproperty
   a_ignore_busy: assert property (p_ignore_busy)
      else $error("write disturbed running sequence");

   // Completion clears start, drives the output low and sets ready
   property p_done_low;
      done |=> !busy && !st_r.mode.start && !st_r.dout && st_r.dout_oe && st_r.ready;
   endproperty
   a_done_low: assert property (p_done_low)
      else $error("completion not signalled");

   // Twelfth edge of each conversion is the load edge
   property p_edge_count;
      (st_r.seq == SEQ_LOAD) && tick |-> st_r.edge_cnt == 4'hb;
   endproperty
   a_edge_count: assert property (p_edge_count)
      else $error("conversion not twelve edges");

   // Whole sequence length in system clocks
   property p_total_time;
      done |-> 32'(st_r.cyc) ==
               `AUX_CONV_EDGES * (32'h1 << avg_log) * (32'h1 << st_r.cfg.div);
   endproperty
   a_total_time: assert property (p_total_time)
      else $error("sequence length wrong");

   // All-ones address leaves the register alone
   property p_addr_none;
      cs_rise && (spi.word[`AUX_ADDR_MSB:`AUX_ADDR_LSB] == `AUX_ADDR_NONE) && !done
      |=> st_r.mode == $past(st_r.mode);
   endproperty
   a_addr_none: assert property (p_addr_none)
      else $error("register changed by unused address");

   // Read frame end releases the pin
   property p_release;
      cs_rise && st_r.reading && !start_go |=> !st_r.dout_oe && !st_r.reading;
   endproperty
   a_release: assert property (p_release)
      else $error("pin not released at select rise");

   // Disabled output never starts a read
   property p_no_read;
      cs_fall && !st_r.mode.out_en && !st_r.reading |=> !st_r.reading;
   endproperty
   a_no_read: assert property (p_no_read)
      else $error("read started while disabled");

   // First bit of a read is the msb
   property p_msb_first;
      cs_fall && st_r.mode.out_en && st_r.ready && !busy
      |=> st_r.dout == st_r.result[`AUX_RES_W-1] && st_r.dout_oe ##1 st_r.reading;
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("read did not start with msb");

   // Accepted start takes the written selections
   property p_select;
      s_go |=> adc_in_sel == $past(spi.word[`AUX_F_INSEL+1:`AUX_F_INSEL]) &&
               adc_ref_sel == $past(spi.word[`AUX_F_REF]);
   endproperty
   a_select: assert property (p_select)
      else $error("selections not taken at start");

endmodule : aux_adc_sequencer

// ===== bench/aux_host_model.sv
`timescale 1ns/1ps

// Serial host plus the analog source seen through the comparator
module aux_host_model (
   output logic            sclk,       // Serial clock, still outside frames
   output logic            cs_n,       // Chip select, active low
   output logic            din,        // Serial data towards the block
   input  wire logic       dout,       // Serial data from the block
   input  wire logic       dout_oe,    // Drive enable of that pin
   input  wire logic [9:0] adc_trial,  // Trial code from the sequencer
   output logic            adc_cmp     // Comparator answer
);
   localparam int HALF = 24;  // Half link period in ns

   logic [9:0] vin_r;     // Analog level expressed as a code
   wire        dout_pin;  // Resolved serial output wire

   // Undriven pin floats
   assign dout_pin = dout_oe ? dout : 1'bz;

   // Input at or above the trial code answers high
   assign adc_cmp = (vin_r >= adc_trial);

   // Idle levels
   initial begin
      sclk  = 1'b0;
      cs_n  = 1'b1;
      din   = 1'b1;
      vin_r = 10'h000;
   end

   // One instruction, msb first, bits taken on rising clock
   task write_word(input logic [15:0] w);
      // Keep frames at least 80 ns apart; return right at select rise
      #100;
      cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         din = w[i];
         #HALF;
         sclk = 1'b1;
         #HALF;
         sclk = 1'b0;
      end
      din = 1'b1;
      cs_n = 1'b1;
   endtask : write_word

   // Result read, sixteen clocks with input high so address all-ones is sent
   task read_result(output logic [9:0] r);
      din = 1'b1;
      cs_n = 1'b0;
      #40;
      for (int i = 15; i >= 0; i--) begin
         if (i >= 6) begin
            r[i-6] = dout_pin;
         end
         sclk = 1'b1;
         #HALF;
         sclk = 1'b0;
         #HALF;
      end
      cs_n = 1'b1;
      #100;
   endtask : read_result
endmodule : aux_host_model

// ===== bench/aux_adc_sequencer_tb.sv
`timescale 1ns/1ps
`include "aux_adc_map.svh"

module aux_adc_sequencer_tb;
   logic       clk;          // System clock
   logic       resetn;       // Synchronous reset, active low
   wire        sclk;         // Link clock from the host
   wire        cs_n;         // Chip select
   wire        din;          // Serial input
   wire        adc_cmp;      // Comparator
   wire        dout;         // Serial output value
   wire        dout_oe;      // Serial output enable
   wire        conv_busy;    // Conversion running
   wire        adc_sample;   // Sample strobe
   wire  [9:0] adc_trial;    // Trial code
   wire        adc_ref_sel;  // Reference choice
   wire  [1:0] adc_in_sel;   // Input choice
   wire        dout_pin;     // Resolved pin
   int         n_errors;     // Mismatches
   int         num_checks;   // Comparisons
   int         busy_cnt;     // Cycles seen busy
   int         smp_cnt;      // Sample strobes seen

   assign dout_pin = dout_oe ? dout : 1'bz;

   aux_adc_sequencer u_dut (
      .clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .din(din),
      .adc_cmp(adc_cmp), .dout(dout), .dout_oe(dout_oe), .conv_busy(conv_busy),
      .adc_sample(adc_sample), .adc_trial(adc_trial),
      .adc_ref_sel(adc_ref_sel), .adc_in_sel(adc_in_sel)
   );

   aux_host_model u_host (
      .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
      .adc_trial(adc_trial), .adc_cmp(adc_cmp)
   );

   // Clock source
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Busy length and strobe count monitor
   always @(negedge clk) begin
      if (conv_busy === 1'b1) begin
         busy_cnt++;
      end
      if (adc_sample === 1'b1) begin
         smp_cnt++;
         // Each conversion sees the input lsb flipped once more
         u_host.vin_r[0] = ~u_host.vin_r[0];
      end
   end

   // Pin or flag compare
   task chk_pin(input string name, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %b seen %b", name, exp, got);
      end
   endtask : chk_pin

   // Value compare
   task chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_val

   // Verdict and end of run
   task summarize;
      if (n_errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   // Levels straight after reset
   task t_reset;
      chk_pin("dout pin", 1'bz, dout_pin);
      chk_pin("conv_busy", 1'b0, conv_busy);
      chk_pin("adc_ref_sel", 1'b0, adc_ref_sel);
      chk_val("adc_in_sel", 16'h0, {14'h0, adc_in_sel});
   endtask : t_reset

   // Start, time, read back; optionally rewrite start while busy
   task t_conv(input logic [2:0] avg, input logic [2:0] dv, input logic [1:0] sel,
               input logic rf, input logic oe, input logic [9:0] v, input bit poke);
      logic [15:0] w;
      logic [9:0]  r;
      int          n;
      int          cnt;
      logic [9:0]  e;
      w = {`AUX_MODE_ADDR, 1'b0, oe, dv, avg, sel, rf, 1'b1};
      n = (avg >= 3'h5) ? 32 : (1 << avg);
      // One conversion sees v^1; an even count averages to v with lsb cut
      e = (n == 1) ? (v ^ 10'h001) : {v[9:1], 1'b0};
      u_host.vin_r = v;
      busy_cnt = 0;
      smp_cnt = 0;
      u_host.write_word(w);
      // Decode lands two to three clocks after select rises
      repeat (4) @(negedge clk);
      chk_pin("conv_busy", 1'b1, conv_busy);
      chk_pin("dout pin", 1'b1, dout_pin);
      chk_pin("adc_ref_sel", rf, adc_ref_sel);
      chk_val("adc_in_sel", {14'h0, sel}, {14'h0, adc_in_sel});
      if (poke) begin
         u_host.write_word(w & 16'hfffe);
         repeat (4) @(negedge clk);
         chk_pin("conv_busy", 1'b1, conv_busy);
         u_host.write_word(w);
         chk_pin("conv_busy", 1'b1, conv_busy);
      end
      for (cnt = 0; conv_busy === 1'b1 && cnt < 20000; cnt++) begin
         @(negedge clk);
      end
      if (cnt == 20000) begin
         n_errors++;
         summarize;
      end
      chk_val("busy cycles", 16'(12 * n * (1 << dv) + 1), 16'(busy_cnt));
      chk_val("samples", 16'(n), 16'(smp_cnt));
      chk_pin("dout pin", 1'b0, dout_pin);
      u_host.read_result(r);
      chk_val("result", oe ? {6'h0, e} : 16'h0, {6'h0, r});
      if (oe) begin
         chk_pin("dout pin", 1'bz, dout_pin);
      end
   endtask : t_conv

   // Writes to the empty address and to a foreign one change nothing
   task t_null;
      logic [3:0] a [2];
      a[0] = `AUX_ADDR_NONE;
      a[1] = 4'h8;
      for (int i = 0; i < 2; i++) begin
         u_host.write_word({a[i], 12'hfff});
         repeat (4) @(negedge clk);
         chk_pin("conv_busy", 1'b0, conv_busy);
         chk_val("adc_in_sel", 16'h2, {14'h0, adc_in_sel});
      end
   endtask : t_null

   // Main sequence
   initial begin
      n_errors = 0;
      num_checks = 0;
      busy_cnt = 0;
      smp_cnt = 0;
      resetn = 1'b0;
      repeat (20) @(negedge clk);
      resetn = 1'b1;
      repeat (4) @(negedge clk);
      t_reset;
      // Every averaging, input and reference code
      for (int a = 0; a < 8; a++) begin
         t_conv(3'(a), 3'h0, 2'(a), 1'(a), 1'b1, 10'(10'h155 + a), 1'b0);
      end
      // Every divisor code from one to seven
      for (int d = 1; d < 8; d++) begin
         t_conv(3'h0, 3'(d), 2'h3, 1'b0, 1'b1, 10'(10'h2aa - d), 1'b0);
      end
      // Output disabled, start rewritten while busy; divide by 64 stays under 4 MHz
      t_conv(3'h1, 3'h6, 2'h2, 1'b1, 1'b0, 10'h3ff, 1'b1);
      t_null;
      summarize;
   end
endmodule : aux_adc_sequencer_tb
